// File: verilog/asc_cmd_handler.sv
// Address slot, slot receive and statistics command handler with an APB register file.
`timescale 1ns/100ps
// Summary of operation
// - Address slot request code 09H echoed.
// - Invalid address write leaves slot unchanged.
// - Address write clears slot receive enable.
// - Wrong class or broadcast write gives D3H.
// - Missing or forbidden slot gives D1H.
// - Success returns zero; not controller gives A1H.
// - Read reply bit 3 shows slot valid.
// - Address slot is physical or multicast; echoed.
// - Read returns prior six byte address.
// - Receive control request code 0AH echoed.
// - Receive control on empty slot gives D2H.
// - Write sets receive enable from mask bit 2.
// - Read reply bit 2 shows prior enable.
// - Receive control on physical, broadcast, multicast.
// - Statistics request code 0BH echoed.
// - Statistics read copies counters to host buffer.
// - Statistics write clears range, after read.
// - Start index out of range touches nothing.
// - Count clipped; actual count reported.
// - User identifier copied back unchanged.
module asc_cmd_handler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Statistics events
  input wire logic [asc_pkg::NUM_STATS-1:0] stat_inc,
  // Host memory write port
  output logic mem_valid,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_data,
  input wire logic mem_ready,
  // Slot receive enables
  output logic [asc_pkg::SLOT_ENTRIES-1:0] slot_rx_en
);
  import asc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  asc_state_type st_r, st_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [31:0] req_hdr_r, req_hdr_nxt, req_uid_r, req_uid_nxt;
  logic [31:0] req_dat0_r, req_dat0_nxt, req_dat1_r, req_dat1_nxt;
  logic [31:0] rpl_hdr_r, rpl_hdr_nxt, rpl_uid_r, rpl_uid_nxt;
  logic [31:0] rpl_dat0_r, rpl_dat0_nxt, rpl_dat1_r, rpl_dat1_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt, ctl_mode_r, ctl_mode_nxt;
  logic [47:0] slot_addr_r [SLOT_ENTRIES];
  logic [47:0] slot_addr_nxt [SLOT_ENTRIES];
  logic [SLOT_ENTRIES-1:0] slot_valid_r, slot_valid_nxt, rx_en_r, rx_en_nxt;
  logic [31:0] stat_r [NUM_STATS];
  logic [31:0] stat_nxt [NUM_STATS];
  logic [15:0] cnt_r, cnt_nxt, k_r, k_nxt;
  logic mem_valid_r, mem_valid_nxt;
  logic [31:0] mem_addr_r, mem_addr_nxt, mem_data_r, mem_data_nxt;

  // ****************************************
  // Request decode
  // ****************************************
  logic [7:0] r_code, r_mask, r_slot;
  logic [15:0] r_num, r_idx;
  logic [47:0] r_addr;
  logic is_mc, is_phys, is_bc, do_wr, do_rd;
  logic [SLOT_IDX_W-1:0] s_idx;
  logic cur_valid, cur_rx, addr_ok, idx_ok;
  logic [15:0] avail, clip;

  always_comb begin
    r_code = req_hdr_r[HDR_CODE_LSB +: 8];
    r_mask = req_hdr_r[HDR_MASK_LSB +: 8];
    r_slot = req_hdr_r[HDR_SLOT_LSB +: 8];
    r_num = req_dat0_r[STAT_NUM_LSB +: 16];
    r_idx = req_dat0_r[STAT_IDX_LSB +: 16];
    r_addr = {req_dat1_r[15:0], req_dat0_r};
    do_wr = r_mask[MASK_WR_BIT];
    do_rd = r_mask[MASK_RD_BIT];
    is_mc = (r_slot >= SLOT_MC_FIRST) && (r_slot <= SLOT_MC_LAST);
    is_phys = (r_slot == SLOT_PHYS);
    is_bc = (r_slot == SLOT_BCAST);
    if (is_phys) begin
      s_idx = SLOT_IDX_PHYS;
    end else if (is_mc) begin
      s_idx = r_slot[SLOT_IDX_W-1:0];
    end else begin
      s_idx = SLOT_IDX_BCAST;
    end
    cur_valid = slot_valid_r[s_idx];
    cur_rx = rx_en_r[s_idx];
    // A zero address is never valid; otherwise the group bit must suit the slot.
    addr_ok = (r_addr != NULL_ADDR) && (r_addr[MCAST_ADDR_BIT] == is_mc);
    idx_ok = (r_idx < STAT_COUNT);
    avail = STAT_COUNT - r_idx;
    clip = !idx_ok ? 16'h0000 : ((r_num > avail) ? avail : r_num);
  end

  // ****************************************
  // Next state
  // ****************************************
  logic acc, fire, mapped;
  logic [7:0] rc;
  logic [7:0] rmask;

  always_comb begin
    st_nxt = st_r;
    pready_nxt = 1'b0;
    pslverr_nxt = pslverr_r;
    prdata_nxt = prdata_r;
    req_hdr_nxt = req_hdr_r;
    req_uid_nxt = req_uid_r;
    req_dat0_nxt = req_dat0_r;
    req_dat1_nxt = req_dat1_r;
    rpl_hdr_nxt = rpl_hdr_r;
    rpl_uid_nxt = rpl_uid_r;
    rpl_dat0_nxt = rpl_dat0_r;
    rpl_dat1_nxt = rpl_dat1_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    ctl_mode_nxt = ctl_mode_r;
    slot_addr_nxt = slot_addr_r;
    slot_valid_nxt = slot_valid_r;
    rx_en_nxt = rx_en_r;
    cnt_nxt = cnt_r;
    k_nxt = k_r;
    mem_valid_nxt = mem_valid_r;
    mem_addr_nxt = mem_addr_r;
    mem_data_nxt = mem_data_r;
    rc = RC_OK;
    rmask = 8'h00;
    // Counters count events until a clear lands on them.
    for (int i = 0; i < NUM_STATS; i++) begin
      stat_nxt[i] = stat_r[i] + 32'(stat_inc[i]);
    end
    // One wait state lets read data come from a flip-flop.
    mapped = (paddr == OFS_REQ_HDR) || (paddr == OFS_REQ_UID) ||
             (paddr == OFS_REQ_DAT0) || (paddr == OFS_REQ_DAT1) ||
             (paddr == OFS_CMD) || (paddr == OFS_CTRL) ||
             (paddr == OFS_RPL_HDR) || (paddr == OFS_RPL_UID) ||
             (paddr == OFS_RPL_DAT0) || (paddr == OFS_RPL_DAT1) ||
             (paddr == OFS_RX_EN);
    acc = psel && penable && !pready_r;
    fire = psel && penable && pready_r && pwrite;
    if (acc) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !mapped;
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        OFS_REQ_HDR: prdata_nxt = req_hdr_r;
        OFS_REQ_UID: prdata_nxt = req_uid_r;
        OFS_REQ_DAT0: prdata_nxt = req_dat0_r;
        OFS_REQ_DAT1: prdata_nxt = req_dat1_r;
        OFS_CMD: begin
          prdata_nxt[STS_BUSY_BIT] = busy_r;
          prdata_nxt[STS_DONE_BIT] = done_r;
        end
        OFS_CTRL: prdata_nxt[CTRL_MODE_BIT] = ctl_mode_r;
        OFS_RPL_HDR: prdata_nxt = rpl_hdr_r;
        OFS_RPL_UID: prdata_nxt = rpl_uid_r;
        OFS_RPL_DAT0: prdata_nxt = rpl_dat0_r;
        OFS_RPL_DAT1: prdata_nxt = rpl_dat1_r;
        OFS_RX_EN: prdata_nxt = 32'(rx_en_r);
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    // The request is frozen while busy so that a reply always matches it.
    if (fire && !busy_r) begin
      unique case (paddr)
        OFS_REQ_HDR: req_hdr_nxt = pwdata;
        OFS_REQ_UID: req_uid_nxt = pwdata;
        OFS_REQ_DAT0: req_dat0_nxt = pwdata;
        OFS_REQ_DAT1: req_dat1_nxt = pwdata;
        OFS_CTRL: ctl_mode_nxt = pwdata[CTRL_MODE_BIT];
        OFS_CMD: begin
          if (pwdata[CMD_GO_BIT]) begin
            busy_nxt = 1'b1;
            done_nxt = 1'b0;
            st_nxt = ST_EXEC;
          end
        end
        default: ;
      endcase
    end
    unique case (st_r)
      ST_IDLE: ;
      ST_EXEC: begin
        rpl_uid_nxt = req_uid_r;
        rpl_dat0_nxt = req_dat0_r;
        rpl_dat1_nxt = req_dat1_r;
        st_nxt = ST_IDLE;
        if (!ctl_mode_r) begin
          rc = RC_NOTCTL;
        end else if (r_code == CODE_ADDRS) begin
          rmask[MASK_VALID_BIT] = cur_valid;
          if (do_rd) begin
            rpl_dat0_nxt = slot_addr_r[s_idx][31:0];
            rpl_dat1_nxt = {16'h0000, slot_addr_r[s_idx][47:32]};
          end
          if (is_bc && do_wr) begin
            rc = RC_BADADDR;
          end else if (!(is_mc || is_phys)) begin
            rc = RC_NOSLOT;
          end else if (do_wr && !addr_ok) begin
            rc = RC_BADADDR;
          end else if (do_wr) begin
            slot_addr_nxt[s_idx] = r_addr;
            slot_valid_nxt[s_idx] = 1'b1;
            rx_en_nxt[s_idx] = 1'b0;
          end
        end else if (r_code == CODE_RECV) begin
          rmask[MASK_EN_BIT] = cur_rx;
          if (!(is_mc || is_phys || is_bc)) begin
            rc = RC_NOSLOT;
          end else if (!cur_valid) begin
            rc = RC_EMPTY;
          end else if (do_wr) begin
            rx_en_nxt[s_idx] = r_mask[MASK_EN_BIT];
          end
        end else if (r_code == CODE_STATS) begin
          cnt_nxt = clip;
          k_nxt = 16'h0000;
          rpl_dat0_nxt[STAT_NUM_LSB +: 16] = clip;
          if (do_rd && clip != 16'h0000) begin
            mem_valid_nxt = 1'b1;
            mem_addr_nxt = req_dat1_r;
            mem_data_nxt = stat_r[r_idx[SLOT_IDX_W-2:0]];
            st_nxt = ST_STAT_RD;
          end else if (do_wr && clip != 16'h0000) begin
            st_nxt = ST_STAT_CLR;
          end
        end else begin
          rc = RC_BADCODE;
        end
        rpl_hdr_nxt = {r_slot, rmask, rc, r_code};
        if (st_nxt == ST_IDLE) begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      ST_STAT_RD: begin
        // Each word is a snapshot taken when it is offered to memory.
        if (mem_ready) begin
          if (k_r + 16'h0001 == cnt_r) begin
            mem_valid_nxt = 1'b0;
            if (do_wr) begin
              st_nxt = ST_STAT_CLR;
            end else begin
              st_nxt = ST_IDLE;
              busy_nxt = 1'b0;
              done_nxt = 1'b1;
            end
          end else begin
            k_nxt = k_r + 16'h0001;
            mem_addr_nxt = mem_addr_r + MEM_STEP;
            mem_data_nxt = stat_r[3'(r_idx + k_r + 16'h0001)];
          end
        end
      end
      ST_STAT_CLR: begin
        for (int i = 0; i < NUM_STATS; i++) begin
          if (16'(i) >= r_idx && 16'(i) < 16'(r_idx + cnt_r)) begin
            stat_nxt[i] = 32'h0000_0000;
          end
        end
        st_nxt = ST_IDLE;
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      req_hdr_r <= 32'h0000_0000;
      req_uid_r <= 32'h0000_0000;
      req_dat0_r <= 32'h0000_0000;
      req_dat1_r <= 32'h0000_0000;
      rpl_hdr_r <= 32'h0000_0000;
      rpl_uid_r <= 32'h0000_0000;
      rpl_dat0_r <= 32'h0000_0000;
      rpl_dat1_r <= 32'h0000_0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ctl_mode_r <= CTRL_MODE_RESET;
      for (int i = 0; i < SLOT_ENTRIES; i++) begin
        slot_addr_r[i] <= NULL_ADDR;
      end
      // The broadcast slot always holds the all-ones address.
      slot_addr_r[SLOT_IDX_BCAST] <= BCAST_ADDR;
      slot_valid_r <= SLOT_ENTRIES'(1) << SLOT_IDX_BCAST;
      rx_en_r <= '0;
      for (int i = 0; i < NUM_STATS; i++) begin
        stat_r[i] <= 32'h0000_0000;
      end
      cnt_r <= 16'h0000;
      k_r <= 16'h0000;
      mem_valid_r <= 1'b0;
      mem_addr_r <= 32'h0000_0000;
      mem_data_r <= 32'h0000_0000;
    end else if (ce) begin
      st_r <= st_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      req_hdr_r <= req_hdr_nxt;
      req_uid_r <= req_uid_nxt;
      req_dat0_r <= req_dat0_nxt;
      req_dat1_r <= req_dat1_nxt;
      rpl_hdr_r <= rpl_hdr_nxt;
      rpl_uid_r <= rpl_uid_nxt;
      rpl_dat0_r <= rpl_dat0_nxt;
      rpl_dat1_r <= rpl_dat1_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      ctl_mode_r <= ctl_mode_nxt;
      slot_addr_r <= slot_addr_nxt;
      slot_valid_r <= slot_valid_nxt;
      rx_en_r <= rx_en_nxt;
      stat_r <= stat_nxt;
      cnt_r <= cnt_nxt;
      k_r <= k_nxt;
      mem_valid_r <= mem_valid_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_data_r <= mem_data_nxt;
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign mem_valid = mem_valid_r;
  assign mem_addr = mem_addr_r;
  assign mem_data = mem_data_r;
  assign slot_rx_en = rx_en_r;

  // ****************************************
  // Checks
  // ****************************************
  logic [7:0] a_rc;
  assign a_rc = rpl_hdr_r[RPL_RC_LSB +: 8];

  property p_code_echo;
    @(posedge clk) disable iff (rst)
      $rose(done_r) |-> rpl_hdr_r[HDR_CODE_LSB +: 8] == r_code;
  endproperty
  a_code_echo: assert property (p_code_echo) else $error("Request code not echoed.");

  property p_uid_echo;
    @(posedge clk) disable iff (rst)
      $rose(done_r) |-> rpl_uid_r == req_uid_r && rpl_hdr_r[RPL_SLOT_LSB +: 8] == r_slot;
  endproperty
  a_uid_echo: assert property (p_uid_echo) else $error("User id or slot not echoed.");

  property p_not_ctl;
    @(posedge clk) disable iff (rst)
      $rose(done_r) && !ctl_mode_r |-> a_rc == RC_NOTCTL;
  endproperty
  a_not_ctl: assert property (p_not_ctl) else $error("Missing A1H outside controller mode.");

  property p_bcast_wr;
    @(posedge clk) disable iff (rst)
      $rose(done_r) && ctl_mode_r && r_code == CODE_ADDRS && is_bc && do_wr
        |-> a_rc == RC_BADADDR;
  endproperty
  a_bcast_wr: assert property (p_bcast_wr) else $error("Broadcast write not refused.");

  property p_wr_clears_rx;
    @(posedge clk) disable iff (rst)
      $rose(done_r) && r_code == CODE_ADDRS && do_wr && a_rc == RC_OK
        |-> !cur_rx && cur_valid && slot_addr_r[s_idx] == r_addr;
  endproperty
  a_wr_clears_rx: assert property (p_wr_clears_rx) else $error("Address write wrong.");

  property p_recv_empty;
    @(posedge clk) disable iff (rst)
      $rose(done_r) && r_code == CODE_RECV && a_rc == RC_EMPTY |-> !cur_valid;
  endproperty
  a_recv_empty: assert property (p_recv_empty) else $error("D2H on a valid slot.");

  property p_stat_range;
    @(posedge clk) disable iff (rst)
      (st_r == ST_STAT_RD || st_r == ST_STAT_CLR) |-> idx_ok && cnt_r != 16'h0000;
  endproperty
  a_stat_range: assert property (p_stat_range) else $error("Statistics out of range.");

  property p_stat_clip;
    @(posedge clk) disable iff (rst)
      $rose(done_r) && ctl_mode_r && r_code == CODE_STATS
        |-> rpl_dat0_r[STAT_NUM_LSB +: 16] == clip && clip <= r_num;
  endproperty
  a_stat_clip: assert property (p_stat_clip) else $error("Statistics count not clipped.");

  property p_mem_hold;
    @(posedge clk) disable iff (rst)
      mem_valid_r && !mem_ready && ce |=> mem_valid_r && $stable(mem_addr_r) && !done_r;
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("Memory write dropped.");

  property p_go_busy;
    @(posedge clk) disable iff (rst)
      busy_r |-> !done_r;
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("Done while busy.");

endmodule // asc_cmd_handler

// File: inc/asc_pkg.sv
// Constants, field layout and state type of the address slot and statistics command handler.
package asc_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  // Configured multicast slot limit and statistics array length.
  localparam int NUM_MCAST = 8;
  localparam int NUM_STATS = 8;
  localparam logic [15:0] STAT_COUNT = 16'(NUM_STATS);
  localparam int SLOT_ENTRIES = NUM_MCAST + 2;
  localparam int SLOT_IDX_W = 4;
  localparam logic [SLOT_IDX_W-1:0] SLOT_IDX_BCAST = 4'h0;
  localparam logic [SLOT_IDX_W-1:0] SLOT_IDX_PHYS = 4'(NUM_MCAST + 1);
  // ****************************************
  // Message codes
  // ****************************************
  localparam logic [7:0] CODE_ADDRS = 8'h09;
  localparam logic [7:0] CODE_RECV = 8'h0A;
  localparam logic [7:0] CODE_STATS = 8'h0B;
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_NOSLOT = 8'hD1;
  localparam logic [7:0] RC_EMPTY = 8'hD2;
  localparam logic [7:0] RC_BADADDR = 8'hD3;
  localparam logic [7:0] RC_NOTCTL = 8'hA1;
  localparam logic [7:0] RC_BADCODE = 8'hFF;
  localparam int MASK_WR_BIT = 0;
  localparam int MASK_RD_BIT = 1;
  localparam int MASK_EN_BIT = 2;
  localparam int MASK_VALID_BIT = 3;
  localparam logic [7:0] SLOT_MC_FIRST = 8'h01;
  localparam logic [7:0] SLOT_MC_LAST = 8'(NUM_MCAST);
  localparam logic [7:0] SLOT_PHYS = 8'hFD;
  localparam logic [7:0] SLOT_BCAST = 8'hFF;
  localparam int MCAST_ADDR_BIT = 40;
  localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] NULL_ADDR = 48'h0000_0000_0000;
  localparam logic [31:0] MEM_STEP = 32'h0000_0004;
  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_REQ_HDR = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_REQ_UID = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_REQ_DAT0 = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_REQ_DAT1 = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_CMD = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_RPL_HDR = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_RPL_UID = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_RPL_DAT0 = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_RPL_DAT1 = 12'h02C;
  localparam logic [ADDR_W-1:0] OFS_RX_EN = 12'h030;
  localparam int HDR_CODE_LSB = 0;
  localparam int HDR_MASK_LSB = 8;
  localparam int HDR_SLOT_LSB = 16;
  localparam int RPL_RC_LSB = 8;
  localparam int RPL_MASK_LSB = 16;
  localparam int RPL_SLOT_LSB = 24;
  localparam int STAT_NUM_LSB = 0;
  localparam int STAT_IDX_LSB = 16;
  localparam int CMD_GO_BIT = 0;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_DONE_BIT = 1;
  localparam int CTRL_MODE_BIT = 0;
  localparam logic CTRL_MODE_RESET = 1'b0;
  typedef enum {ST_IDLE, ST_EXEC, ST_STAT_RD, ST_STAT_CLR} asc_state_type;
endpackage

// File: verification/asc_host_mem.sv
// Host shared memory model that takes statistics words from the handler.
`timescale 1ns/100ps
module asc_host_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Memory write port
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_data,
  output logic mem_ready,
  // Pacing
  input wire logic slow
);
  logic [31:0] words [0:15];
  int writes;
  // A slow host stalls every other cycle, so the handler must hold each word.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ready <= 1'b0;
      writes <= 0;
    end else begin
      mem_ready <= slow ? ~mem_ready : 1'b1;
      if (mem_valid && mem_ready) begin
        words[mem_addr[5:2]] <= mem_data;
        writes <= writes + 1;
      end
    end
  end
endmodule // asc_host_mem

// File: verification/tb_top.sv
// Self-checking bench for the address slot and statistics command handler.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import asc_pkg::*;
  localparam logic [31:0] PA0 = 32'h3344_5566;
  localparam logic [31:0] PA1 = 32'h0000_0211;
  localparam logic [31:0] PB0 = 32'h7788_99AA;
  localparam logic [31:0] PB1 = 32'h0000_04BB;
  localparam logic [31:0] MA1 = 32'h0000_0111;
  localparam logic [31:0] BUF = 32'h0000_0100;
  localparam int VB = RPL_MASK_LSB + MASK_VALID_BIT;
  localparam int EB = RPL_MASK_LSB + MASK_EN_BIT;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [NUM_STATS-1:0] stat_inc = '0;
  logic slow = 1'b0;
  logic pready, pslverr, mem_valid, mem_ready, err;
  logic [31:0] prdata, mem_addr, mem_data, q, hdr, d0, d1;
  logic [31:0] uid = 32'h1234_5678;
  logic [SLOT_ENTRIES-1:0] slot_rx_en;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  asc_cmd_handler dut (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .stat_inc(stat_inc), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_ready(mem_ready), .slot_rx_en(slot_rx_en));
  asc_host_mem host (.clk(clk), .rst(rst), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_ready(mem_ready), .slow(slow));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // Bus and command tasks
  // ****************************************
  // Pready is read at each rising edge before the design updates it, so the edge at
  // which it reads high is the edge that completes the transfer; only the bench
  // timeout ends a wait that never finishes.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] code, input logic [7:0] mask, input logic [7:0] slot,
    input logic [31:0] a0, input logic [31:0] a1, input logic [7:0] rc);
    uid = uid + 32'h0101_0101;
    apb(1'b1, OFS_REQ_HDR, {8'h00, slot, mask, code});
    apb(1'b1, OFS_REQ_UID, uid);
    apb(1'b1, OFS_REQ_DAT0, a0);
    apb(1'b1, OFS_REQ_DAT1, a1);
    apb(1'b1, OFS_CMD, 32'h0000_0001);
    do begin
      apb(1'b0, OFS_CMD, 32'h0000_0000);
    end while (q[STS_DONE_BIT] !== 1'b1);
    apb(1'b0, OFS_RPL_HDR, 32'h0000_0000);
    hdr = q;
    apb(1'b0, OFS_RPL_UID, 32'h0000_0000);
    `CHK(q, uid)
    apb(1'b0, OFS_RPL_DAT0, 32'h0000_0000);
    d0 = q;
    apb(1'b0, OFS_RPL_DAT1, 32'h0000_0000);
    d1 = q;
    `CHK(hdr[7:0], code)
    `CHK(hdr[31:24], slot)
    `CHK(hdr[15:8], rc)
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cmd(CODE_ADDRS, 8'h02, SLOT_PHYS, 32'h0, 32'h0, RC_NOTCTL);
    cmd(CODE_RECV, 8'h02, SLOT_PHYS, 32'h0, 32'h0, RC_NOTCTL);
    cmd(CODE_STATS, 8'h02, 8'h00, 32'h0000_0001, BUF, RC_NOTCTL);
    apb(1'b0, 12'h100, 32'h0000_0000);
    `CHK({err, q}, {1'b1, 32'h0000_0000})
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    cmd(CODE_ADDRS, 8'h02, SLOT_PHYS, 32'h0, 32'h0, RC_OK);
    `CHK(hdr[VB], 1'b0)
    cmd(CODE_RECV, 8'h02, SLOT_PHYS, 32'h0, 32'h0, RC_EMPTY);
    cmd(CODE_ADDRS, 8'h01, SLOT_PHYS, PA0, PA1, RC_OK);
    cmd(CODE_RECV, 8'h05, SLOT_PHYS, 32'h0, 32'h0, RC_OK);
    `CHK(slot_rx_en[9], 1'b1)
    cmd(CODE_RECV, 8'h03, SLOT_PHYS, 32'h0, 32'h0, RC_OK);
    `CHK({hdr[EB], slot_rx_en[9]}, 2'b10)
    cmd(CODE_RECV, 8'h05, SLOT_PHYS, 32'h0, 32'h0, RC_OK);
    cmd(CODE_ADDRS, 8'h03, SLOT_PHYS, PB0, PB1, RC_OK);
    `CHK({hdr[VB], d0, d1[15:0]}, {1'b1, PA0, PA1[15:0]})
    `CHK(slot_rx_en[9], 1'b0)
    cmd(CODE_ADDRS, 8'h01, SLOT_PHYS, PA0, MA1, RC_BADADDR);
    cmd(CODE_ADDRS, 8'h02, SLOT_PHYS, 32'h0, 32'h0, RC_OK);
    `CHK({d0, d1[15:0]}, {PB0, PB1[15:0]})
    cmd(CODE_ADDRS, 8'h01, SLOT_BCAST, PA0, MA1, RC_BADADDR);
    cmd(CODE_ADDRS, 8'h01, SLOT_MC_FIRST, PA0, PA1, RC_BADADDR);
    cmd(CODE_ADDRS, 8'h01, SLOT_MC_LAST, PA0, MA1, RC_OK);
    cmd(CODE_ADDRS, 8'h02, SLOT_MC_LAST + 8'h01, 32'h0, 32'h0, RC_NOSLOT);
    cmd(CODE_RECV, 8'h05, 8'h00, 32'h0, 32'h0, RC_NOSLOT);
    cmd(CODE_RECV, 8'h05, SLOT_BCAST, 32'h0, 32'h0, RC_OK);
    cmd(CODE_RECV, 8'h05, SLOT_MC_LAST, 32'h0, 32'h0, RC_OK);
    apb(1'b0, OFS_RX_EN, 32'h0000_0000);
    `CHK(q[9:0], 10'h101)
    slow <= 1'b1;
    stat_inc <= 8'h05;
    repeat (3) @(posedge clk);
    stat_inc <= 8'h00;
    cmd(CODE_STATS, 8'h03, 8'h00, 32'h0000_0004, BUF, RC_OK);
    `CHK(d0[15:0], 16'h0004)
    for (int i = 0; i < 4; i++) begin
      `CHK(host.words[i], ((i % 2) == 0) ? 32'h0000_0003 : 32'h0000_0000)
    end
    cmd(CODE_STATS, 8'h02, 8'h00, 32'h0000_0008, BUF, RC_OK);
    `CHK({d0[15:0], host.words[0], host.words[2]}, {16'h0008, 64'h0})
    cmd(CODE_STATS, 8'h02, 8'h00, 32'h0006_0005, BUF, RC_OK);
    `CHK(d0[15:0], 16'h0002)
    cmd(CODE_STATS, 8'h03, 8'h00, 32'h0008_0002, BUF, RC_OK);
    `CHK({d0[15:0], host.writes}, {16'h0000, 32'd14})
    complete_run();
  end
endmodule // tb_top
